// File: logic/tse_map.svh
// Purpose: Constants for the selector-store, subtract and test unit
// Assumes: Included by its bare name
// Notes: Opcode bytes, reg-field codes and flag positions
`ifndef TSE_MAP_SVH
`define TSE_MAP_SVH
`define TSE_OP_TWO_BYTE 8'h0F
`define TSE_OP_GRP6 8'h00
`define TSE_REG_STORE_SEL 3'h1
`define TSE_OP_SUB_AL_IB 8'h2C
`define TSE_OP_SUB_AX_IV 8'h2D
`define TSE_OP_GRP1_IB 8'h80
`define TSE_OP_GRP1_IV 8'h81
`define TSE_OP_GRP1_SIB 8'h83
`define TSE_REG_SUB 3'h5
`define TSE_OP_SUB_RM_R8 8'h28
`define TSE_OP_SUB_RM_RV 8'h29
`define TSE_OP_SUB_R_RM8 8'h2A
`define TSE_OP_SUB_R_RMV 8'h2B
`define TSE_OP_TEST_AL_IB 8'hA8
`define TSE_OP_TEST_AX_IV 8'hA9
`define TSE_OP_GRP3_B 8'hF6
`define TSE_OP_GRP3_V 8'hF7
`define TSE_REG_TEST 3'h0
`define TSE_OP_TEST_RM_R8 8'h84
`define TSE_OP_TEST_RM_RV 8'h85
`define TSE_CPL_USER 2'h3
`define TSE_FLAG_CARRY 0
`define TSE_FLAG_PARITY 2
`define TSE_FLAG_AUX 4
`define TSE_FLAG_ZERO 6
`define TSE_FLAG_SIGN 7
`define TSE_FLAG_OVF 11
`endif

// File: logic/tse_pkg.sv
// Purpose: Types for the selector-store, subtract and test unit
// Assumes: None
// Notes: Size and fault encodings
package tse_pkg;
  typedef enum logic [1:0] {
    TSE_SZ_8 = 2'h0,
    TSE_SZ_16 = 2'h1,
    TSE_SZ_32 = 2'h2
  } tse_size_t;
  typedef enum logic [2:0] {
    TSE_FLT_NONE = 3'h0,
    TSE_FLT_UD = 3'h1,
    TSE_FLT_GP = 3'h2,
    TSE_FLT_SS = 3'h3,
    TSE_FLT_PF = 3'h4,
    TSE_FLT_AC = 3'h5
  } tse_fault_t;
endpackage

// File: logic/tse_alu.sv
// Purpose: Subtract and AND datapath with flag generation
// Assumes: Operands already sign-extended to the width
// Notes: Combinational; flags in EFLAGS bit order
`timescale 1ns/1ns
`include "tse_map.svh"
module tse_alu
  import tse_pkg::*;
(
  // Operands
  input wire logic [31:0] i_dst,
  input wire logic [31:0] i_src,
  input wire tse_size_t i_size,
  input wire logic i_is_and,
  // Results
  output logic [31:0] o_res,
  output logic [11:0] o_flags
);
  function automatic logic msb_of(input logic [31:0] v,
                                  input tse_size_t s);
    msb_of = (s == TSE_SZ_8) ? v[7] : (s == TSE_SZ_16) ? v[15] : v[31];
  endfunction
  function automatic logic [31:0] trim(input logic [31:0] v,
                                       input tse_size_t s);
    trim = (s == TSE_SZ_8) ? {24'h000000, v[7:0]} :
           (s == TSE_SZ_16) ? {16'h0000, v[15:0]} : v;
  endfunction
  wire logic [31:0] a = trim(i_dst, i_size);
  wire logic [31:0] b = trim(i_src, i_size);
  wire logic [32:0] diff = {1'b0, a} - {1'b0, b};
  wire logic [31:0] res = trim(i_is_and ? (a & b) : diff[31:0], i_size);
  wire logic sa = msb_of(a, i_size);
  wire logic sb = msb_of(b, i_size);
  wire logic sr = msb_of(res, i_size);
  wire logic borrow = a < b;
  wire logic ovf = (sa != sb) && (sr != sa);
  wire logic aux = a[3:0] < b[3:0];
  assign o_res = res;
  always_comb begin
    o_flags = 12'h000;
    o_flags[`TSE_FLAG_CARRY] = i_is_and ? 1'b0 : borrow;
    o_flags[`TSE_FLAG_OVF] = i_is_and ? 1'b0 : ovf;
    o_flags[`TSE_FLAG_SIGN] = sr;
    o_flags[`TSE_FLAG_ZERO] = (res == 32'h00000000);
    o_flags[`TSE_FLAG_PARITY] = ~^res[7:0];
    o_flags[`TSE_FLAG_AUX] = i_is_and ? 1'b0 : aux;
  end
endmodule

// File: logic/tse_exec.sv
// Purpose: Execute stage for selector store, subtract and test
// Assumes: Decode supplies opcode, reg field, operands, fault probes
// Notes: One-cycle issue, result registered the next edge
`timescale 1ns/1ns
`include "tse_map.svh"
module tse_exec
  import tse_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Decoded instruction
  input wire logic i_valid,
  input wire logic i_two_byte,
  input wire logic [7:0] i_opcode,
  input wire logic [2:0] i_reg_field,
  input wire logic i_opsize32,
  input wire logic i_dst_is_mem,
  input wire logic [31:0] i_dst_val,
  input wire logic [31:0] i_src_val,
  input wire logic [31:0] i_imm,
  // Machine state
  input wire logic i_prot_mode,
  input wire logic i_v86_mode,
  input wire logic [1:0] i_cpl,
  input wire logic i_align_chk_en,
  input wire logic [15:0] i_task_register,
  input wire logic [11:0] i_flags,
  // Memory probes
  input wire logic i_seg_writable,
  input wire logic i_seg_null,
  input wire logic i_seg_is_stack,
  input wire logic i_limit_fail,
  input wire logic i_xlate_fail,
  input wire logic [15:0] i_pf_code,
  input wire logic i_unaligned,
  // Results
  output logic o_done,
  output logic o_reg_we,
  output logic o_mem_we,
  output logic [1:0] o_wr_size,
  output logic [31:0] o_wr_data,
  output logic [11:0] o_flags,
  output logic o_fault,
  output tse_fault_t o_fault_kind,
  output logic o_fault_has_code,
  output logic [15:0] o_fault_code
);
  ////////////////////////////////////////////////////////////////////
  // Decode
  typedef enum logic [3:0] {
    TSE_K_NONE = 4'b0001,
    TSE_K_STORE = 4'b0010,
    TSE_K_SUB = 4'b0100,
    TSE_K_TEST = 4'b1000
  } tse_kind_t;
  function automatic logic [31:0] sx8(input logic [7:0] v);
    sx8 = {{24{v[7]}}, v};
  endfunction
  function automatic logic [31:0] sx16(input logic [15:0] v);
    sx16 = {{16{v[15]}}, v};
  endfunction
  wire logic is_store = i_two_byte && i_opcode == `TSE_OP_GRP6
    && i_reg_field == `TSE_REG_STORE_SEL;
  wire logic sub_acc = !i_two_byte && (i_opcode == `TSE_OP_SUB_AL_IB
    || i_opcode == `TSE_OP_SUB_AX_IV);
  wire logic sub_grp = !i_two_byte && i_reg_field == `TSE_REG_SUB
    && (i_opcode == `TSE_OP_GRP1_IB || i_opcode == `TSE_OP_GRP1_IV
    || i_opcode == `TSE_OP_GRP1_SIB);
  wire logic sub_rr = !i_two_byte && (i_opcode == `TSE_OP_SUB_RM_R8
    || i_opcode == `TSE_OP_SUB_RM_RV || i_opcode == `TSE_OP_SUB_R_RM8
    || i_opcode == `TSE_OP_SUB_R_RMV);
  wire logic tst_acc = !i_two_byte && (i_opcode == `TSE_OP_TEST_AL_IB
    || i_opcode == `TSE_OP_TEST_AX_IV);
  wire logic tst_grp = !i_two_byte && i_reg_field == `TSE_REG_TEST
    && (i_opcode == `TSE_OP_GRP3_B || i_opcode == `TSE_OP_GRP3_V);
  wire logic tst_rr = !i_two_byte && (i_opcode == `TSE_OP_TEST_RM_R8
    || i_opcode == `TSE_OP_TEST_RM_RV);
  wire logic is_sub = sub_acc || sub_grp || sub_rr;
  wire logic is_test = tst_acc || tst_grp || tst_rr;
  wire logic use_imm = sub_acc || sub_grp || tst_acc || tst_grp;
  // Byte forms have even opcodes except the 83 sign-extend form
  wire logic byte_op = !i_opcode[0] && i_opcode != `TSE_OP_GRP1_SIB
    && !is_store;
  wire tse_size_t size = byte_op ? TSE_SZ_8 :
                         (i_opsize32 ? TSE_SZ_32 : TSE_SZ_16);
  wire logic imm8_form = i_opcode == `TSE_OP_GRP1_SIB || byte_op;
  wire logic [31:0] imm_ext = imm8_form ? sx8(i_imm[7:0]) :
    (size == TSE_SZ_16 ? sx16(i_imm[15:0]) : i_imm);
  wire logic [31:0] src = use_imm ? imm_ext : i_src_val;
  wire tse_kind_t kind = !i_valid ? TSE_K_NONE :
                         is_store ? TSE_K_STORE :
                         is_sub ? TSE_K_SUB :
                         is_test ? TSE_K_TEST : TSE_K_NONE;
  ////////////////////////////////////////////////////////////////////
  // Datapath
  logic [31:0] alu_res;
  logic [11:0] alu_flags;
  tse_alu u_alu (
    .i_dst(i_dst_val),
    .i_src(src),
    .i_size(size),
    .i_is_and(is_test),
    .o_res(alu_res),
    .o_flags(alu_flags)
  );
  ////////////////////////////////////////////////////////////////////
  // Faults
  wire logic mem_access = i_dst_is_mem && kind != TSE_K_NONE;
  wire logic real_mode = !i_prot_mode;
  wire logic pm_only = i_prot_mode && !i_v86_mode;
  wire logic f_ud = kind == TSE_K_STORE && !pm_only;
  wire logic f_wr = pm_only && mem_access && kind != TSE_K_TEST
    && !i_seg_writable;
  wire logic f_null = pm_only && mem_access && i_seg_null;
  wire logic f_lim_gp = mem_access && i_limit_fail
    && !i_seg_is_stack;
  wire logic f_lim_ss = mem_access && i_limit_fail
    && i_seg_is_stack;
  wire logic f_pf = !real_mode && mem_access && i_xlate_fail;
  wire logic f_ac = !real_mode && mem_access && i_align_chk_en
    && i_unaligned && (i_v86_mode || i_cpl == `TSE_CPL_USER);
  wire tse_fault_t fault_nxt = f_ud ? TSE_FLT_UD :
    (f_wr || f_null || f_lim_gp) ? TSE_FLT_GP :
    f_lim_ss ? TSE_FLT_SS :
    f_pf ? TSE_FLT_PF :
    f_ac ? TSE_FLT_AC : TSE_FLT_NONE;
  wire logic any_fault = fault_nxt != TSE_FLT_NONE;
  wire logic code_nxt = !real_mode && fault_nxt != TSE_FLT_UD
    && any_fault;
  wire logic [15:0] fcode_nxt = fault_nxt == TSE_FLT_PF ? i_pf_code
    : 16'h0000;
  ////////////////////////////////////////////////////////////////////
  // Write-back selection
  wire logic [31:0] store_data = {16'h0000, i_task_register};
  wire logic ok = kind != TSE_K_NONE && !any_fault;
  wire logic wr_nxt = ok && kind != TSE_K_TEST;
  wire logic [1:0] wsz_nxt = kind == TSE_K_STORE
    ? (i_dst_is_mem ? TSE_SZ_16 : size) : size;
  wire logic [31:0] wdata_nxt = kind == TSE_K_STORE ? store_data
    : alu_res;
  wire logic [11:0] flags_nxt = (ok && kind != TSE_K_STORE)
    ? alu_flags : i_flags;
  ////////////////////////////////////////////////////////////////////
  // Output registers
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_done <= 1'b0;
      o_reg_we <= 1'b0;
      o_mem_we <= 1'b0;
      o_wr_size <= 2'h0;
      o_wr_data <= 32'h00000000;
      o_flags <= 12'h000;
      o_fault <= 1'b0;
      o_fault_kind <= TSE_FLT_NONE;
      o_fault_has_code <= 1'b0;
      o_fault_code <= 16'h0000;
    end else begin
      o_done <= kind != TSE_K_NONE;
      o_reg_we <= wr_nxt && !i_dst_is_mem;
      o_mem_we <= wr_nxt && i_dst_is_mem;
      o_wr_size <= wsz_nxt;
      o_wr_data <= wdata_nxt;
      o_flags <= flags_nxt;
      o_fault <= any_fault;
      o_fault_kind <= fault_nxt;
      o_fault_has_code <= code_nxt;
      o_fault_code <= fcode_nxt;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Checks
  AST_STORE_UD: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_valid && is_store && !pm_only |=> o_fault
    && o_fault_kind == TSE_FLT_UD && !o_reg_we && !o_mem_we)
    else $error("store outside protected mode not refused");
  AST_STORE_ZX: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_valid && is_store && pm_only && !i_dst_is_mem |=>
    o_reg_we && o_wr_data == {16'h0000, $past(i_task_register)})
    else $error("selector not zero-extended");
  AST_STORE_MEM16: assert property (@(posedge i_clk)
    disable iff (!i_rstn)
    o_mem_we && $past(is_store) |-> o_wr_size == TSE_SZ_16)
    else $error("selector memory store not 16 bits");
  AST_STORE_FLAGS: assert property (@(posedge i_clk)
    disable iff (!i_rstn)
    i_valid && is_store |=> o_flags == $past(i_flags))
    else $error("selector store changed flags");
  AST_TEST_NOWR: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_valid && is_test |=> !o_reg_we && !o_mem_we)
    else $error("test result written");
  AST_TEST_CLR: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_valid && is_test && !any_fault |=> !o_flags[`TSE_FLAG_CARRY]
    && !o_flags[`TSE_FLAG_OVF])
    else $error("test left carry or overflow set");
  AST_SUB_RES: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_valid && is_sub && !any_fault && i_opsize32 && !byte_op |=>
    o_wr_data == $past(i_dst_val) - $past(src))
    else $error("subtract difference wrong");
  AST_SUB_CARRY: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_valid && is_sub && !any_fault && size == TSE_SZ_32 |=>
    o_flags[`TSE_FLAG_CARRY] == ($past(i_dst_val) < $past(src)))
    else $error("carry not unsigned borrow");
  AST_NULL_GP: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_valid && kind != TSE_K_NONE && pm_only && i_dst_is_mem
    && i_seg_null && !f_ud |=> o_fault_kind == TSE_FLT_GP
    && o_fault_code == 16'h0000)
    else $error("null selector not faulted");
  AST_REAL_NOCODE: assert property (@(posedge i_clk)
    disable iff (!i_rstn)
    o_fault && $past(real_mode) |-> !o_fault_has_code)
    else $error("real mode fault carries a code");
  AST_STORE_MEM_DATA: assert property (@(posedge i_clk)
    disable iff (!i_rstn)
    i_valid && is_store && i_dst_is_mem && !any_fault |=> o_mem_we
    && o_wr_data[15:0] == $past(i_task_register))
    else $error("selector not written to memory");
  AST_WR_GP: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_valid && (is_store || is_sub) && pm_only && i_dst_is_mem
    && !i_seg_writable |=> o_fault_kind == TSE_FLT_GP
    && o_fault_code == 16'h0000)
    else $error("non-writable destination not faulted");
  AST_LIM_SS: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_valid && kind != TSE_K_NONE && !f_ud && !f_wr && !f_null
    && i_dst_is_mem && i_limit_fail && i_seg_is_stack
    |=> o_fault_kind == TSE_FLT_SS)
    else $error("stack limit breach not faulted");
  AST_PF_CODE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_fault_kind == TSE_FLT_PF |-> o_fault_has_code
    && o_fault_code == $past(i_pf_code))
    else $error("page fault code not carried");
  AST_AC_MODE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_fault_kind == TSE_FLT_AC |-> $past(i_prot_mode)
    && $past(i_align_chk_en))
    else $error("alignment fault outside its mode");
  AST_FAULT_NOWR: assert property (@(posedge i_clk)
    disable iff (!i_rstn)
    o_fault |-> !o_reg_we && !o_mem_we)
    else $error("faulted instruction wrote back");
  AST_SUB_IMM83: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_valid && sub_grp && i_opcode == `TSE_OP_GRP1_SIB
    |-> src == sx8(i_imm[7:0]))
    else $error("short immediate not sign-extended");
  AST_SUB_ZERO: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_valid && is_sub && !any_fault && i_dst_val == src
    && size == TSE_SZ_32 |=> o_flags[`TSE_FLAG_ZERO]
    && !o_flags[`TSE_FLAG_CARRY])
    else $error("equal operands not zero");
  AST_TEST_SIGN: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_valid && is_test && !any_fault && size == TSE_SZ_32 |=>
    o_flags[`TSE_FLAG_SIGN] == ($past(i_dst_val[31])
    && $past(src[31])))
    else $error("test sign flag wrong");
  AST_TEST_ZF: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_valid && is_test && !any_fault && size == TSE_SZ_32 |=>
    o_flags[`TSE_FLAG_ZERO] == (($past(i_dst_val) & $past(src))
    == 32'h00000000))
    else $error("test zero flag wrong");
  AST_UNKNOWN_IDLE: assert property (@(posedge i_clk)
    disable iff (!i_rstn)
    kind == TSE_K_NONE |=> !o_done && !o_reg_we && !o_mem_we
    && !o_fault)
    else $error("unknown opcode retired");
  AST_STORE_SIZE: assert property (@(posedge i_clk)
    disable iff (!i_rstn)
    i_valid && is_store && pm_only && !i_dst_is_mem && i_opsize32
    |=> o_reg_we && o_wr_size == TSE_SZ_32)
    else $error("selector register store size wrong");
endmodule

// File: verif/tse_exec_test.sv
// Purpose: Self-checking bench for the store, subtract and test unit
// Assumes: Results appear one cycle after an accepted instruction
// Notes: Driver queues expectations; monitor pops them on o_done
`timescale 1ns/1ns
module tse_exec_test;
  import tse_pkg::*;
  typedef struct {
    logic rwe, mwe;
    logic [1:0] sz;
    logic [31:0] dat;
    logic [11:0] fl;
    tse_fault_t fk;
    logic hc;
    logic [15:0] fc;
  } tse_exp_t;
  logic i_clk = 0, i_rstn = 0, i_valid = 0, i_two_byte = 0;
  logic i_opsize32 = 0, i_dst_is_mem = 0, i_prot_mode = 1, i_v86_mode = 0;
  logic i_align_chk_en = 0, i_seg_writable = 1, i_seg_null = 0;
  logic i_seg_is_stack = 0, i_limit_fail = 0, i_xlate_fail = 0;
  logic i_unaligned = 0;
  logic [7:0] i_opcode = 0;
  logic [2:0] i_reg_field = 0;
  logic [1:0] i_cpl = 0;
  logic [31:0] i_dst_val = 0, i_src_val = 0, i_imm = 0;
  logic [15:0] i_task_register = 0, i_pf_code = 0;
  logic [11:0] i_flags = 0;
  logic o_done, o_reg_we, o_mem_we, o_fault, o_fault_has_code;
  logic [1:0] o_wr_size;
  logic [31:0] o_wr_data;
  logic [11:0] o_flags;
  tse_fault_t o_fault_kind;
  logic [15:0] o_fault_code;
  tse_exp_t q[$];
  int error_cnt = 0;
  int num_checks = 0;

  tse_exec DUT (.i_clk, .i_rstn, .i_valid, .i_two_byte, .i_opcode,
    .i_reg_field, .i_opsize32, .i_dst_is_mem, .i_dst_val, .i_src_val,
    .i_imm, .i_prot_mode, .i_v86_mode, .i_cpl, .i_align_chk_en,
    .i_task_register, .i_flags, .i_seg_writable, .i_seg_null,
    .i_seg_is_stack, .i_limit_fail, .i_xlate_fail, .i_pf_code,
    .i_unaligned, .o_done, .o_reg_we, .o_mem_we, .o_wr_size, .o_wr_data,
    .o_flags, .o_fault, .o_fault_kind, .o_fault_has_code, .o_fault_code);

  initial forever #5 i_clk = ~i_clk;
////////////////////////////////////////////////////////////////////////
  // Reference model of one instruction
  function automatic logic model(output tse_exp_t e);
    logic st, sb, ts, byt, gp, ss;
    logic [31:0] m, hb, a, b, r;
    st = i_two_byte && i_opcode == 8'h00 && i_reg_field == 3'h1;
    sb = !i_two_byte && (i_opcode inside {[8'h28:8'h2D]} ||
      i_opcode inside {8'h80, 8'h81, 8'h83} && i_reg_field == 3'h5);
    ts = !i_two_byte && (i_opcode inside {8'h84, 8'h85, 8'hA8, 8'hA9} ||
      i_opcode inside {8'hF6, 8'hF7} && i_reg_field == 3'h0);
    byt = !i_opcode[0];
    m = byt ? 32'hFF : i_opsize32 ? 32'hFFFFFFFF : 32'hFFFF;
    hb = m & ~(m >> 1);
    b = i_src_val;
    if (i_opcode inside {[8'h2C:8'h2D], [8'h80:8'h83], [8'hA8:8'hA9],
        [8'hF6:8'hF7]})
      b = byt || i_opcode == 8'h83 ? {{24{i_imm[7]}}, i_imm[7:0]} :
        i_opsize32 ? i_imm : {{16{i_imm[15]}}, i_imm[15:0]};
    a = i_dst_val & m;
    b = b & m;
    r = (ts ? a & b : a - b) & m;
    e.fl = '0;
    e.fl[0] = !ts && a < b;
    e.fl[2] = ~^r[7:0];
    e.fl[4] = !ts && (a[4] ^ b[4] ^ r[4]);
    e.fl[6] = r == 0;
    e.fl[7] = |(r & hb);
    e.fl[11] = !ts && |((a ^ b) & (a ^ r) & hb);
    e.sz = byt ? 2'h0 : i_opsize32 ? 2'h2 : 2'h1;
    e.dat = r;
    if (st) begin
      e.fl = i_flags;
      e.sz = i_opsize32 && !i_dst_is_mem ? 2'h2 : 2'h1;
      e.dat = {16'h0000, i_task_register};
    end
    e.rwe = !ts && !i_dst_is_mem;
    e.mwe = !ts && i_dst_is_mem;
    gp = i_dst_is_mem && (i_limit_fail && !i_seg_is_stack || i_prot_mode
      && !i_v86_mode && (i_seg_null || !ts && !i_seg_writable));
    ss = i_dst_is_mem && i_limit_fail && i_seg_is_stack;
    e.fk = st && (!i_prot_mode || i_v86_mode) ? TSE_FLT_UD :
      gp ? TSE_FLT_GP : ss ? TSE_FLT_SS :
      i_dst_is_mem && i_prot_mode && i_xlate_fail ? TSE_FLT_PF :
      i_dst_is_mem && i_prot_mode && i_align_chk_en && i_unaligned &&
      (i_v86_mode || i_cpl == 2'h3) ? TSE_FLT_AC : TSE_FLT_NONE;
    e.hc = e.fk inside {TSE_FLT_PF, TSE_FLT_AC} ||
      e.fk inside {TSE_FLT_GP, TSE_FLT_SS} && i_prot_mode;
    e.fc = e.fk == TSE_FLT_PF ? i_pf_code : 16'h0000;
    if (e.fk != TSE_FLT_NONE) begin
      e.rwe = 1'b0;
      e.mwe = 1'b0;
      e.fl = i_flags;
    end
    return st || sb || ts;
  endfunction
////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    if (error_cnt == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic go(input logic tb, input logic [7:0] op,
    input logic [2:0] rf);
    tse_exp_t e;
    i_two_byte = tb;
    i_opcode = op;
    i_reg_field = rf;
    if (model(e))
      q.push_back(e);
    i_valid = 1'b1;
    @(negedge i_clk);
  endtask
////////////////////////////////////////////////////////////////////////
  // Monitor
  always @(posedge i_clk) begin
    tse_exp_t e;
    #1;
    if (o_done === 1'b1) begin
      if (q.size() == 0) begin
        chk(1'b1, 1'b0);
      end else begin
        e = q.pop_front();
        chk(o_reg_we, e.rwe);
        chk(o_mem_we, e.mwe);
        chk(o_flags, e.fl);
        chk(o_fault_kind, e.fk);
        chk(o_fault, e.fk != TSE_FLT_NONE);
        if (e.fk != TSE_FLT_NONE) begin
          chk(o_fault_has_code, e.hc);
          chk(o_fault_code, e.fc);
        end else if (e.rwe || e.mwe) begin
          chk(o_wr_size, e.sz);
          chk(o_wr_data & (e.sz == 2'h0 ? 32'hFF : e.sz == 2'h1 ?
            32'hFFFF : 32'hFFFFFFFF), e.dat);
        end
      end
    end
  end

  initial begin
    #60000;
    error_cnt++;
    stop_test();
  end
////////////////////////////////////////////////////////////////////////
  // Stimulus
  initial begin
    int k;
    logic [7:0] op;
    logic [7:0] ops [16] = '{8'h2C, 8'h2D, 8'h80, 8'h81, 8'h83, 8'h28,
      8'h29, 8'h2A, 8'h2B, 8'hA8, 8'hA9, 8'hF6, 8'hF7, 8'h84, 8'h85, 8'h00};
    k = $urandom(32'hAF1400AD);
    repeat (3) @(negedge i_clk);
    i_rstn = 1'b1;
    for (k = 0; k < 6; k++) begin
      i_opsize32 = k[0];
      i_dst_is_mem = k[1];
      i_prot_mode = k != 4;
      i_v86_mode = k == 5;
      i_task_register = $urandom;
      i_flags = $urandom;
      go(1'b1, 8'h00, 3'h1);
    end
    i_v86_mode = 1'b0;
    i_prot_mode = 1'b1;
    go(1'b1, 8'h00, 3'h4);
    go(1'b0, 8'h80, 3'h3);
    i_dst_is_mem = 1'b0;
    i_dst_val = 32'h5;
    i_src_val = 32'h7;
    go(1'b0, 8'h29, 3'h0);
    for (k = 0; k < 800; k++) begin
      op = ops[k % 16];
      i_opsize32 = $urandom;
      i_dst_val = $urandom;
      i_src_val = k % 4 == 0 ? i_dst_val : k % 4 == 1 ? ~i_dst_val :
        $urandom;
      i_imm = i_src_val;
      i_flags = $urandom;
      i_task_register = $urandom;
      i_cpl = $urandom;
      i_pf_code = $urandom;
      i_dst_is_mem = !(op inside {[8'h2A:8'h2D], 8'hA8, 8'hA9}) && $urandom;
      i_prot_mode = k < 400 || $urandom_range(0, 3) != 0;
      i_v86_mode = i_prot_mode && k >= 400 && $urandom_range(0, 3) == 0;
      i_seg_writable = k < 400 || $urandom_range(0, 3) != 0;
      {i_seg_null, i_seg_is_stack, i_limit_fail, i_xlate_fail, i_unaligned,
        i_align_chk_en} = k < 400 ? 6'h00 : 6'($urandom & $urandom);
      go(op == 8'h00, op, op inside {[8'h80:8'h83]} ? 3'h5 :
        op inside {8'hF6, 8'hF7} ? 3'h0 : op == 8'h00 ? 3'h1 :
        3'($urandom));
      if (k % 7 == 0) begin
        i_valid = 1'b0;
        @(negedge i_clk);
      end
    end
    i_valid = 1'b0;
    for (k = 0; k < 10 && q.size() > 0; k++)
      @(negedge i_clk);
    chk(q.size(), 0);
    stop_test();
  end
endmodule
